//--- logic/stc_defs.svh
// constants for the serializer transmit channel
// assumes inclusion by both ends and the bench
//
// Notes on behaviour
// - capture on host clock or reference clock
// - host clock, full rate: through align buffer
// - reference clock full rate: buffer bypassed
// - buffer tolerates half character phase drift
// - overflow asserts error until reinitialized
// - writing reset latch zero reinitializes buffer
// - send fixed error character while error; code sends it only with buffer in use and pattern off
// - pattern generator repeats 511 characters
// - device reset clears pattern enables
// - character inputs ignored while pattern active
// - bit clock is reference times 10/20
// - speed range and rate limit reference
// - drivers enabled singly; both off powers down
// - device reset disables all drivers
// - host resets buffer after re-enable
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define STC_CHAR_W      10
`define STC_ERR_CHAR    10'h278
`define STC_LFSR_SEED   9'h1ff
`define STC_LFSR_PERIOD 511
`define STC_BUF_DEPTH   4
`define STC_BITS_FULL   10
`define STC_BITS_HALF   20
`define STC_RESTART_US  250
`define STC_CLK_NS      100
`define STC_RESTART_CYC ((`STC_RESTART_US * 1000) / `STC_CLK_NS)
`endif

//--- logic/stc_pkg.sv
// types for the serializer transmit channel
// assumes stc_defs.svh is compiled alongside
package stc_pkg;
  typedef logic [9:0] stc_char_t;
  typedef enum logic [1:0] {STC_SPD_LOW, STC_SPD_MID, STC_SPD_HIGH} stc_speed_e;
endpackage : stc_pkg

//--- logic/stc_link_if.sv
// link between host end and device transmit end
// assumes bench connects clocks
`timescale 1ns/1ps
`default_nettype none
interface stc_link_if;
  logic             host_tx_clock;
  stc_pkg::stc_char_t tx_char_in;
  logic             char_clock_out;
  logic             phase_align_error;
  logic             input_clock_select;
  logic             ref_rate_select;
  logic             phase_align_reset_latch;
  logic             pattern_gen_enable;
  logic [1:0]       driver_enable;
  stc_pkg::stc_speed_e speed_range_select;
  logic             serial_out;
  modport device (input host_tx_clock, tx_char_in, input_clock_select, ref_rate_select,
                  phase_align_reset_latch, pattern_gen_enable, driver_enable,
                  speed_range_select,
                  output char_clock_out, phase_align_error, serial_out);
  modport host (output host_tx_clock, tx_char_in, input_clock_select, ref_rate_select,
                phase_align_reset_latch, pattern_gen_enable, driver_enable,
                speed_range_select,
                input char_clock_out, phase_align_error, serial_out);
endinterface : stc_link_if
`default_nettype wire

//--- logic/stc_device.sv
// transmit channel: capture, phase-align buffer, pattern generator, shifter
// assumes ref_clock_in is the link clock; bit clock is modelled by bit_clock
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_device (
  input wire logic     ref_clock_in,
  input wire logic     bit_clock,
  input wire logic     rst_n,
  stc_link_if.device   link,
  output logic         channel_powered,
  output logic [1:0]   driver_active
);
  // ----------------------------------------
  // configuration latches, two flops from the host clock
  // ----------------------------------------
  logic       patS1, patEn;
  logic [1:0] drvS1, drvEn;
  logic       latS1, parLatch;
  logic       selS1, selSync;
  logic       rateS1, rateSync;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      patS1    <= 1'b0;
      patEn    <= 1'b0;
      drvS1    <= 2'b00;
      drvEn    <= 2'b00;
      latS1    <= 1'b1;
      parLatch <= 1'b1;
      selS1    <= 1'b0;
      selSync  <= 1'b0;
      rateS1   <= 1'b0;
      rateSync <= 1'b0;
    end else begin
      patS1    <= link.pattern_gen_enable;
      patEn    <= patS1;
      drvS1    <= link.driver_enable;
      drvEn    <= drvS1;
      latS1    <= link.phase_align_reset_latch;
      parLatch <= latS1;
      selS1    <= link.input_clock_select;
      selSync  <= selS1;
      rateS1   <= link.ref_rate_select;
      rateSync <= rateS1;
    end
  end
  logic chanOn;
  assign chanOn = |drvEn;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_powered <= 1'b0;
      driver_active   <= 2'b00;
    end else begin
      channel_powered <= chanOn;
      driver_active   <= drvEn;
    end
  end
  // ----------------------------------------
  // character clock: full rate every edge, half rate every second
  // ----------------------------------------
  logic charTick;
  logic halfPh;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) halfPh <= 1'b0;
    else        halfPh <= ~halfPh;
  end
  assign charTick = ~rateSync | halfPh;
  // ----------------------------------------
  // host-clock capture and gray write pointer
  // ----------------------------------------
  localparam int AW = 2;
  stc_pkg::stc_char_t   mem [`STC_BUF_DEPTH];
  logic [AW-1:0] wrPtr, wrGray;
  logic          wrRst1, wrRst2;
  always_ff @(posedge link.host_tx_clock or negedge rst_n) begin
    if (!rst_n) begin
      wrRst1 <= 1'b1;
      wrRst2 <= 1'b1;
    end else begin
      wrRst1 <= ~parLatch;
      wrRst2 <= wrRst1;
    end
  end
  always_ff @(posedge link.host_tx_clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr  <= '0;
      wrGray <= '0;
    end else if (wrRst2) begin
      wrPtr  <= '0;
      wrGray <= '0;
    end else begin
      wrPtr  <= wrPtr + 2'd1;
      wrGray <= (wrPtr + 2'd1) ^ ((wrPtr + 2'd1) >> 1);
    end
  end
  always_ff @(posedge link.host_tx_clock) begin
    mem[wrPtr] <= link.tx_char_in;
  end
  // ----------------------------------------
  // read side, drift check on reference clock
  // ----------------------------------------
  logic [AW-1:0] wg1, wg2, rdPtr, rdGray;
  logic          err;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      wg1 <= '0;
      wg2 <= '0;
    end else begin
      wg1 <= wrGray;
      wg2 <= wg1;
    end
  end
  logic useBuf;
  assign useBuf = ~selSync & ~rateSync;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr  <= 2'd2;
      rdGray <= 2'd3;
      err    <= 1'b0;
    end else if (!parLatch || !chanOn) begin
      rdPtr  <= 2'd2;  // half depth behind the writer
      rdGray <= 2'd3;
      err    <= 1'b0;
    end else if (useBuf && charTick) begin
      rdPtr  <= rdPtr + 2'd1;
      rdGray <= (rdPtr + 2'd1) ^ ((rdPtr + 2'd1) >> 1);
      if (wg2 == rdGray) err <= 1'b1;  // collision: drift past capacity
    end
  end
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) link.phase_align_error <= 1'b0;
    else        link.phase_align_error <= err & parLatch & chanOn;
  end
  // ----------------------------------------
  // reference-clock capture and pattern generator
  // ----------------------------------------
  stc_pkg::stc_char_t refS1, refCap, nextChar, curChar;
  logic [8:0]        lfsr;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      refS1  <= '0;
      refCap <= '0;
    end else begin
      refS1  <= link.tx_char_in;
      refCap <= refS1;
    end
  end
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n)                 lfsr <= `STC_LFSR_SEED;
    else if (!patEn)            lfsr <= `STC_LFSR_SEED;
    else if (charTick)          lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
  end
  always_comb begin
    if (patEn)                        nextChar = {lfsr[0], lfsr};
    else if (useBuf && err)           nextChar = `STC_ERR_CHAR;
    else if (useBuf)                  nextChar = mem[rdPtr];
    else                              nextChar = refCap;
  end
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n)        curChar <= '0;
    else if (charTick) curChar <= nextChar;
  end
  // ----------------------------------------
  // shifter on bit clock, character handed over by toggle
  // ----------------------------------------
  logic tgl, t1, t2, t3;
  always_ff @(posedge ref_clock_in or negedge rst_n) begin
    if (!rst_n)        tgl <= 1'b0;
    else if (charTick) tgl <= ~tgl;
  end
  logic [9:0] sh;
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n) begin
      t1 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
    end else begin
      t1 <= tgl;
      t2 <= t1;
      t3 <= t2;
    end
  end
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n)         sh <= '0;
    else if (t2 != t3)  sh <= curChar;
    else                sh <= {1'b0, sh[9:1]};
  end
  // power state brought over to the bit clock
  logic onS1, onBit;
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n) begin
      onS1  <= 1'b0;
      onBit <= 1'b0;
    end else begin
      onS1  <= chanOn;
      onBit <= onS1;
    end
  end
  // char clock: high for the first five bit clocks of each character
  logic [3:0] bitCnt;
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n)              bitCnt <= 4'hf;
    else if (t2 != t3)       bitCnt <= 4'h0;
    else if (bitCnt != 4'hf) bitCnt <= bitCnt + 4'h1;
  end
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n) link.char_clock_out <= 1'b0;
    else        link.char_clock_out <= (t2 != t3) || (bitCnt < 4'h4);
  end
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n) link.serial_out <= 1'b0;
    else        link.serial_out <= sh[0] & onBit;
  end
endmodule : stc_device
`default_nettype wire

//--- logic/stc_host.sv
// host end: drives characters on its own divided clock and the configuration
// assumes clk at 10 MHz, link clock made here by a divider
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_host (
  input wire logic            clk,
  input wire logic            rst_n,
  stc_link_if.host            link,
  input wire logic [9:0]      user_char,
  input wire logic            user_clock_select,
  input wire logic            user_rate_select,
  input wire logic            user_pattern_enable,
  input wire logic [1:0]      user_driver_enable,
  input wire logic            user_align_reset,
  output logic                user_error
);
  logic e1, e2, prevOn;
  logic [15:0] wait_cnt;
  logic reEnable;
  assign reEnable = !prevOn && |user_driver_enable;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.host_tx_clock <= 1'b0;
      link.tx_char_in    <= '0;
      link.input_clock_select <= 1'b0;
      link.ref_rate_select    <= 1'b0;
      link.pattern_gen_enable <= 1'b0;
      link.driver_enable      <= 2'b00;
      link.speed_range_select <= stc_pkg::STC_SPD_MID;
    end else begin
      link.host_tx_clock <= ~link.host_tx_clock;
      if (link.host_tx_clock) link.tx_char_in <= user_char;
      link.input_clock_select <= user_clock_select;
      link.ref_rate_select    <= user_rate_select;
      link.pattern_gen_enable <= user_pattern_enable;
      link.driver_enable      <= user_driver_enable;
    end
  end
  // re-enable forces an align reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevOn   <= 1'b0;
      wait_cnt <= '0;
      link.phase_align_reset_latch <= 1'b0;
    end else begin
      prevOn <= |user_driver_enable;
      if (reEnable)                       wait_cnt <= 16'(`STC_RESTART_CYC);
      else if (wait_cnt != '0)            wait_cnt <= wait_cnt - 16'd1;
      // no release pulse on the re-enable edge itself
      link.phase_align_reset_latch <= ~user_align_reset && (wait_cnt == '0) && !reEnable;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e1 <= 1'b0;
      e2 <= 1'b0;
      user_error <= 1'b0;
    end else begin
      e1 <= link.phase_align_error;
      e2 <= e1;
      user_error <= e2;
    end
  end
endmodule : stc_host
`default_nettype wire

//--- verification/stc_link_assertions.sv
// checker: timing relations on the link between host end and device end
// assumes tb_top wires it beside the link interface
`timescale 1ns/1ps
`default_nettype none
module stc_link_assertions (
  input wire logic                clk,
  input wire logic                ref_clock_in,
  input wire logic                bit_clock,
  input wire logic                rst_n,
  input wire logic                host_tx_clock,
  input wire logic                phase_align_error,
  input wire logic                phase_align_reset_latch,
  input wire logic                pattern_gen_enable,
  input wire logic                ref_rate_select,
  input wire logic [1:0]          driver_enable,
  input wire stc_pkg::stc_speed_e speed_range_select,
  input wire logic                serial_out
);
  // ---------------------------------
  // helper: bits spent in error
  // ---------------------------------
  logic [5:0] errBits;
  always_ff @(posedge bit_clock or negedge rst_n) begin
    if (!rst_n) errBits <= 6'h00;
    else if (!phase_align_error) errBits <= 6'h00;
    else if (errBits != 6'h3f) errBits <= errBits + 6'h01;
  end
  sequence latch_released;
    $fell(phase_align_reset_latch);
  endsequence
  sequence latch_held;
    !phase_align_reset_latch [*8];
  endsequence
  // ---------------------------------
  // assertions
  // ---------------------------------
  rst_clear_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    $rose(rst_n) |-> !phase_align_error && !pattern_gen_enable && driver_enable == 2'b00)
    else $error("state not cleared by reset");
  err_hold_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    phase_align_error && phase_align_reset_latch && driver_enable != 2'b00 |=> phase_align_error)
    else $error("error dropped without reinit");
  err_clear_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    latch_released |-> ##[1:4] !phase_align_error) else $error("error not cleared by reinit");
  power_down_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    driver_enable == 2'b00 |-> ##[0:3] !phase_align_error) else $error("error kept while off");
  reinit_hold_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    $rose(driver_enable != 2'b00) |-> ##2 latch_held) else $error("no reinit after re-enable");
  host_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> host_tx_clock != $past(host_tx_clock)) else $error("host clock not halved");
  speed_legal_a: assert property (@(posedge ref_clock_in) disable iff (!rst_n)
    !(speed_range_select == stc_pkg::STC_SPD_LOW && ref_rate_select))
    else $error("reserved speed and rate");
  err_period_a: assert property (@(posedge bit_clock) disable iff (!rst_n)
    errBits == 6'h3f |-> serial_out == $past(serial_out, 10)) else $error("error char not repeated");
endmodule : stc_link_assertions
`default_nettype wire

//--- verification/tb_top.sv
// testbench: host end and device end joined by the link interface
// assumes stc_defs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module tb_top;
  logic        clk        = 1'b0;
  logic        refClk     = 1'b0;
  logic        bitClk     = 1'b0;
  logic        rst_n      = 1'b0;
  logic [9:0]  userChar   = 10'h000;
  logic        userSel    = 1'b1;
  logic        userPat    = 1'b0;
  logic [1:0]  userDrv    = 2'b00;
  logic        userReinit = 1'b0;
  logic        scramble   = 1'b0;
  logic        userRate   = 1'b0;
  logic        userError;
  logic        powered;
  logic [1:0]  drvActive;
  logic [31:0] rng        = 32'h028c1db1;
  logic        cap [10220];
  int          drvQ [$]   = '{1, 2, 0, 3};
  int          bad;
  int          per;
  logic [9:0]  model [$];
  int          miscompares = 0;
  int          n_compared  = 0;
  always #50 clk = ~clk;
  always #32 refClk = ~refClk;
  always #3.2 bitClk = ~bitClk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  always @(posedge clk) begin
    rng <= xs(rng);
    if (scramble) userChar <= rng[9:0];
  end
  stc_link_if link ();
  stc_host i_stc_host (.clk(clk), .rst_n(rst_n), .link(link.host), .user_char(userChar),
    .user_clock_select(userSel), .user_rate_select(userRate), .user_pattern_enable(userPat),
    .user_driver_enable(userDrv), .user_align_reset(userReinit), .user_error(userError));
  stc_device i_stc_device (.ref_clock_in(refClk), .bit_clock(bitClk), .rst_n(rst_n),
    .link(link.device), .channel_powered(powered), .driver_active(drvActive));
  stc_link_assertions i_stc_link_assertions (.clk(clk), .ref_clock_in(refClk),
    .bit_clock(bitClk), .rst_n(rst_n), .host_tx_clock(link.host_tx_clock),
    .phase_align_error(link.phase_align_error),
    .phase_align_reset_latch(link.phase_align_reset_latch),
    .pattern_gen_enable(link.pattern_gen_enable), .ref_rate_select(link.ref_rate_select),
    .driver_enable(link.driver_enable), .speed_range_select(link.speed_range_select),
    .serial_out(link.serial_out));
  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic capture(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge bitClk);
      cap[i] = link.serial_out;
    end
  endtask : capture
  // bit clocks between two rising edges of the character clock
  task automatic charPeriod(output int n);
    int   first;
    logic p;
    first = -1;
    n     = 0;
    p     = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge bitClk);
      if (link.char_clock_out && !p && first >= 0 && n == 0) n = i - first;
      if (link.char_clock_out && !p && first < 0) first = i;
      p = link.char_clock_out;
    end
  endtask : charPeriod
  // some rotation of k equals the first ten captured bits
  function automatic logic [31:0] rotOk(input logic [9:0] k);
    logic [9:0]  w;
    logic [31:0] hit;
    hit = 0;
    for (int i = 0; i < 10; i++) w[i] = cap[i];
    for (int r = 0; r < 10; r++) if (((k >> r) | (k << (10 - r))) === w) hit = 1;
    return hit;
  endfunction : rotOk
  task automatic waitErr(input logic v);
    int k;
    k = 0;
    while (userError !== v && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k == 4000) begin
      miscompares++;
      results();
    end else begin
      chk(link.phase_align_error, v);
    end
  endtask : waitErr
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    chk(drvActive, 0);
    chk(link.pattern_gen_enable, 0);
    foreach (drvQ[i]) begin
      userDrv <= 2'(drvQ[i]);
      cyc(6);
      chk(drvActive, drvQ[i]);
      chk(powered, drvQ[i] != 0);
    end
    scramble <= 1'b1;
    cyc(1);
    scramble <= 1'b0;
    cyc(2600);
    model.push_back(userChar);
    capture(10);
    chk(rotOk(model.pop_front()), 1);
    charPeriod(per);
    chk(per, `STC_BITS_FULL);
    chk(userError, 0);
    userSel <= 1'b0;
    waitErr(1'b1);
    model.push_back(`STC_ERR_CHAR);
    capture(10);
    chk(rotOk(model.pop_front()), 1);
    cyc(20);
    chk(userError, 1);
    userReinit <= 1'b1;
    cyc(2);
    chk(link.phase_align_reset_latch, 0);
    waitErr(1'b0);
    userReinit <= 1'b0;
    userSel <= 1'b1;
    cyc(20);
    chk(userError, 0);
    userPat <= 1'b1;
    scramble <= 1'b1;
    cyc(5);
    capture(10220);
    bad = 0;
    for (int i = 0; i < 5110; i++) if (cap[i] !== cap[i + 5110]) bad++;
    chk(bad, 0);
    rst_n <= 1'b0;
    cyc(2);
    chk(link.pattern_gen_enable, 0);
    chk(drvActive, 0);
    rst_n <= 1'b1;
    cyc(4);
    chk(userError, 0);
    results();
  end
endmodule : tb_top
`default_nettype wire
